/* design/byte_move_pkg.sv */
// Shared constants and types for the byte move and swap execution unit
package byte_move_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam logic [15:0] SHORT_LO = 16'hFE20;
  localparam logic [15:0] SHORT_HI = 16'hFF1F;
  localparam logic [15:0] SFR_HOLE_LO = 16'hFFD0;
  localparam logic [15:0] SFR_HOLE_HI = 16'hFFDF;
  localparam logic [15:0] SFR_LO = 16'hFF00;
  localparam logic [15:0] CALL_LO = 16'h0800;
  localparam logic [15:0] CALL_HI = 16'h0FFF;
  localparam logic [15:0] TABLE_LO = 16'h0040;
  localparam logic [15:0] TABLE_HI = 16'h007F;
  localparam logic [15:0] HSRAM_LO = 16'hFB00;
  localparam logic [15:0] HSRAM_HI = 16'hFEFF;
  localparam int unsigned PSW_Z_BIT = 6;
  localparam int unsigned PSW_AC_BIT = 4;
  localparam int unsigned PSW_CY_BIT = 0;
  localparam logic [7:0] PSW_FLAG_MASK = 8'h51;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_B = 3'h3;
  localparam logic [1:0] PAIR_HL = 2'h3;
  localparam logic [3:0] CYC_RR = 4'h2;
  localparam logic [3:0] CYC_IMM = 4'h4;
  localparam logic [3:0] CYC_SHORT_FAST = 4'h4;
  localparam logic [3:0] CYC_SHORT_SLOW = 4'h5;
  localparam logic [3:0] CYC_ABS_FAST = 4'h8;
  localparam logic [3:0] CYC_ABS_SLOW = 4'h9;
  localparam logic [3:0] CYC_SWAP_SLOW = 4'hA;
  localparam logic [3:0] CYC_IND_FAST = 4'h4;
  localparam logic [3:0] CYC_IND_SLOW = 4'h5;
  localparam logic [3:0] CYC_IDX_FAST = 4'h6;
  localparam logic [3:0] CYC_IDX_SLOW = 4'h7;
  localparam logic [3:0] CYC_PSW_IMM = 4'h7;

  // Operand source / destination kind of a byte transfer
  typedef enum logic [2:0] {
    OPD_REG   = 3'h0,
    OPD_IMM   = 3'h1,
    OPD_SHORT = 3'h2,
    OPD_SFR   = 3'h3,
    OPD_ABS   = 3'h4,
    OPD_IND   = 3'h5,
    OPD_PSW   = 3'h6
  } opd_kind_t;

  // Index mode of indirect operands
  typedef enum logic [1:0] {
    IDX_NONE = 2'h0,
    IDX_DISP = 2'h1,
    IDX_B    = 2'h2,
    IDX_C    = 2'h3
  } idx_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } exec_state_t;
endpackage : byte_move_pkg

/* design/reg_file_if.sv */
// Register file port bundle between the executor and its register bank memory
`timescale 1ns/1ns
`default_nettype none
interface reg_file_if;
  logic [1:0] bank;
  logic [2:0] rd_sel;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [2:0] wr_sel;
  logic [7:0] wr_data;
  logic [7:0] x_q;
  logic [7:0] a_q;
  logic [7:0] b_q;
  logic [7:0] c_q;
  logic [7:0] l_q;
  logic [7:0] h_q;
  logic [7:0] e_q;
  logic [7:0] d_q;
  modport core (output bank, rd_sel, wr_en, wr_sel, wr_data,
                input rd_data, x_q, a_q, b_q, c_q, l_q, h_q, e_q, d_q);
  modport mem (input bank, rd_sel, wr_en, wr_sel, wr_data,
               output rd_data, x_q, a_q, b_q, c_q, l_q, h_q, e_q, d_q);
endinterface : reg_file_if
`default_nettype wire

/* design/reg_bank_mem.sv */
// Four banks of eight general byte registers with registered read port
`timescale 1ns/1ns
`default_nettype none
module reg_bank_mem (
  input  wire logic clock_i,
  input  wire logic rst_i,
  reg_file_if.mem   rf
);
  import byte_move_pkg::*;
  logic [7:0] regs_r [4][8];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int b = 0; b < 4; b++) begin
        for (int r = 0; r < 8; r++) begin
          regs_r[b][r] <= 8'h00;
        end
      end
    end else if (rf.wr_en) begin
      regs_r[rf.bank][rf.wr_sel] <= rf.wr_data;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rf.rd_data <= 8'h00;
    end else begin
      rf.rd_data <= regs_r[rf.bank][rf.rd_sel];
    end
  end

  // Pair halves of the active bank, used for address forming
  assign rf.x_q = regs_r[rf.bank][0];
  assign rf.a_q = regs_r[rf.bank][1];
  assign rf.c_q = regs_r[rf.bank][2];
  assign rf.b_q = regs_r[rf.bank][3];
  assign rf.e_q = regs_r[rf.bank][4];
  assign rf.d_q = regs_r[rf.bank][5];
  assign rf.l_q = regs_r[rf.bank][6];
  assign rf.h_q = regs_r[rf.bank][7];
endmodule : reg_bank_mem
`default_nettype wire

/* design/byte_move_exec.sv */
// Byte move and swap execution unit with operand range checks and cycle timing
// Operation
// RQ1: Registers 0..7 are X A C B E D L H
// RQ2: Pairs 0..3 are AX BC DE HL
// RQ3: Short direct only FE20-FF1F, word form even
// RQ4: Absolute spans all; word transfer needs even
// RQ5: Call address limited to 0800-0FFF
// RQ6: Table address even within 0040-007F
// RQ7: Special registers cannot reach FFD0-FFDF
// RQ8: Bit field three bits, bank 0..3
// RQ9: Branch displacement signed byte added to PC
// RQ10: A is the byte accumulator
// RQ11: AX word accumulator, X low A high
// RQ12: Status word loads overwrite Z AC CY
// RQ13: Fast RAM or no access: short count
// RQ14: Other memory accesses take long count
// RQ15: Indirect address pair plus disp/B/C
// RQ16: Other moves leave flags unchanged
// RQ17: Swap exchanges accumulator and operand
`timescale 1ns/1ns
`default_nettype none
module byte_move_exec (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      start_i,
  input  wire logic                      swap_i,
  input  wire logic                      to_acc_i,
  input  wire byte_move_pkg::opd_kind_t  kind_i,
  input  wire logic [2:0]                reg_sel_i,
  input  wire logic [1:0]                pair_sel_i,
  input  wire byte_move_pkg::idx_mode_t  idx_i,
  input  wire logic [15:0]               addr_i,
  input  wire logic [7:0]                imm_i,
  input  wire logic [1:0]                bank_i,
  input  wire logic                      word_i,
  input  wire logic [2:0]                bit_i,
  input  wire logic [10:0]               call_addr_i,
  input  wire logic [4:0]                table_addr_i,
  input  wire logic [7:0]                branch_disp_i,
  input  wire logic [15:0]               pc_i,
  input  wire logic [7:0]                mem_rdata_i,
  output logic                           busy_o,
  output logic                           done_o,
  output logic                           range_err_o,
  output logic [15:0]                    mem_addr_o,
  output logic                           mem_we_o,
  output logic [7:0]                     mem_wdata_o,
  output logic [7:0]                     program_status_word_o,
  output logic [15:0]                    word_accumulator_o,
  output logic [15:0]                    call_target_o,
  output logic [15:0]                    table_target_o,
  output logic [15:0]                    branch_target_o,
  output logic [7:0]                     bit_mask_o,
  output logic [3:0]                     cycles_o
);
  import byte_move_pkg::*;

  function automatic logic in_range(input logic [15:0] a, lo, hi);
    return (a >= lo) && (a <= hi);
  endfunction : in_range

  reg_file_if rf ();
  reg_bank_mem u_mem (.clock_i(clock_i), .rst_i(rst_i), .rf(rf));

  exec_state_t state_r;
  logic [3:0]  cnt_r;
  logic        swap_r;
  logic        to_acc_r;
  opd_kind_t   kind_r;
  logic [2:0]  reg_r;
  logic [7:0]  imm_r;
  logic [7:0]  acc_old_r;

  // Indirect address: pair plus optional index
  logic [15:0] pair_val;
  logic [15:0] ind_addr;
  logic [15:0] eff_addr;
  logic        bad_addr;
  logic        slow;
  logic [3:0]  cyc_nxt;

  always_comb begin
    unique case (pair_sel_i)  // [RQ2]
      2'h0:    pair_val = {rf.a_q, rf.x_q};
      2'h1:    pair_val = {rf.b_q, rf.c_q};
      2'h2:    pair_val = {rf.d_q, rf.e_q};
      default: pair_val = {rf.h_q, rf.l_q};
    endcase
    unique case (idx_i)  // [RQ15]
      IDX_NONE: ind_addr = pair_val;
      IDX_DISP: ind_addr = pair_val + {8'h00, imm_i};
      IDX_B:    ind_addr = pair_val + {8'h00, rf.b_q};
      IDX_C:    ind_addr = pair_val + {8'h00, rf.c_q};
    endcase
    eff_addr = (kind_i == OPD_IND) ? ind_addr : addr_i;
    bad_addr = 1'b0;
    if (kind_i == OPD_SHORT) begin
      bad_addr = !in_range(addr_i, SHORT_LO, SHORT_HI) || (word_i && addr_i[0]);  // [RQ3]
    end
    if (kind_i == OPD_ABS && word_i && addr_i[0]) begin
      bad_addr = 1'b1;  // [RQ4]
    end
    if (kind_i == OPD_SFR) begin
      bad_addr = addr_i < SFR_LO || in_range(addr_i, SFR_HOLE_LO, SFR_HOLE_HI)
                 || (word_i && addr_i[0]);  // [RQ7]
    end
    slow = !in_range(eff_addr, HSRAM_LO, HSRAM_HI);
    unique case (kind_i)  // [RQ13] [RQ14]
      OPD_REG:   cyc_nxt = CYC_RR;
      OPD_IMM:   cyc_nxt = (swap_i && reg_sel_i == REG_X && imm_i[7]) ? CYC_PSW_IMM : CYC_IMM;
      OPD_PSW:   cyc_nxt = CYC_SHORT_SLOW;
      OPD_SFR:   cyc_nxt = swap_i ? CYC_SWAP_SLOW - CYC_IMM : CYC_SHORT_SLOW;
      OPD_SHORT: cyc_nxt = slow ? (swap_i ? CYC_SHORT_SLOW + 4'h1 : CYC_SHORT_SLOW)
                               : CYC_SHORT_FAST;
      OPD_ABS:   cyc_nxt = slow ? (swap_i ? CYC_SWAP_SLOW : CYC_ABS_SLOW) : CYC_ABS_FAST;
      OPD_IND: begin
        if (idx_i == IDX_NONE) begin
          cyc_nxt = slow ? CYC_IND_SLOW + {3'h0, swap_i} : CYC_IND_FAST;
        end else if (idx_i == IDX_DISP || swap_i) begin
          cyc_nxt = slow ? CYC_ABS_SLOW + {3'h0, swap_i} : CYC_ABS_FAST;
        end else begin
          // Register-indexed moves are shorter than displacement moves
          cyc_nxt = slow ? CYC_IDX_SLOW : CYC_IDX_FAST;
        end
      end
      default:   cyc_nxt = CYC_RR;
    endcase
  end

  // Sequencer: counts the instruction's clocks
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (start_i && !bad_addr) begin
          state_r <= ST_WAIT;
          cnt_r   <= cyc_nxt - 4'h1;
        end
        ST_WAIT: if (cnt_r <= 4'h1) state_r <= ST_DONE;
                 else cnt_r <= cnt_r - 4'h1;
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      swap_r <= 1'b0; to_acc_r <= 1'b0; kind_r <= OPD_REG;
      reg_r <= REG_X; imm_r <= 8'h00; acc_old_r <= 8'h00;
      mem_addr_o <= 16'h0000; cycles_o <= 4'h0; range_err_o <= 1'b0;
    end else if (state_r == ST_IDLE && start_i) begin
      range_err_o <= bad_addr;
      if (!bad_addr) begin
        swap_r <= swap_i; to_acc_r <= to_acc_i; kind_r <= kind_i;
        reg_r <= reg_sel_i; imm_r <= imm_i; acc_old_r <= rf.a_q;  // [RQ10]
        mem_addr_o <= eff_addr; cycles_o <= cyc_nxt;
      end
    end
  end

  // Register bank select and read of the named operand
  assign rf.bank   = bank_i;  // [RQ8]
  assign rf.rd_sel = (state_r == ST_IDLE) ? reg_sel_i : reg_r;  // [RQ1]

  logic       finish;
  logic [7:0] opnd;
  assign finish = (state_r == ST_WAIT) && (cnt_r <= 4'h1);
  assign opnd   = (kind_r == OPD_REG) ? rf.rd_data
                : (kind_r == OPD_IMM) ? imm_r
                : (kind_r == OPD_PSW) ? program_status_word_o : mem_rdata_i;

  // Second write of a register swap lands in DONE
  logic swap_back;
  assign swap_back = (state_r == ST_DONE) && swap_r && kind_r == OPD_REG;

  // Immediate status word load writes no register
  always_comb begin
    rf.wr_en   = 1'b0;
    rf.wr_sel  = REG_A;
    rf.wr_data = opnd;
    if (finish && !(kind_r == OPD_IMM && swap_r)) begin
      if (swap_r || to_acc_r) begin
        rf.wr_en = 1'b1;  // [RQ10] [RQ17]
      end else if (kind_r == OPD_REG || kind_r == OPD_IMM) begin
        rf.wr_en   = 1'b1;  // [RQ1]
        rf.wr_sel  = reg_r;
        rf.wr_data = (kind_r == OPD_REG) ? acc_old_r : imm_r;
      end
    end
    if (swap_back) begin
      rf.wr_en   = 1'b1;  // [RQ17]
      rf.wr_sel  = reg_r;
      rf.wr_data = acc_old_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mem_we_o <= 1'b0; mem_wdata_o <= 8'h00;
    end else begin
      mem_we_o <= finish && (swap_r || !to_acc_r) && kind_r != OPD_REG
                  && kind_r != OPD_IMM && kind_r != OPD_PSW;  // [RQ17]
      mem_wdata_o <= acc_old_r;
    end
  end

  // Flags change only on status word loads
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      program_status_word_o <= PSW_RESET;
    end else if (finish && kind_r == OPD_PSW && !to_acc_r) begin
      program_status_word_o <= acc_old_r;  // [RQ12]
    end else if (finish && kind_r == OPD_IMM && reg_r == REG_X && imm_r[7] && to_acc_r == 1'b0
                 && swap_r) begin
      program_status_word_o <= imm_r;  // [RQ12]
    end else begin
      program_status_word_o <= program_status_word_o;  // [RQ16]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      busy_o <= 1'b0; done_o <= 1'b0; word_accumulator_o <= 16'h0000;
      call_target_o <= 16'h0000; table_target_o <= 16'h0000;
      branch_target_o <= 16'h0000; bit_mask_o <= 8'h00;
    end else begin
      busy_o <= (state_r == ST_IDLE) ? (start_i && !bad_addr) : !(state_r == ST_DONE);
      done_o <= finish;
      word_accumulator_o <= {rf.a_q, rf.x_q};  // [RQ11]
      call_target_o <= CALL_LO | {5'h00, call_addr_i};  // [RQ5]
      table_target_o <= TABLE_LO | {10'h000, table_addr_i, 1'b0};  // [RQ6]
      branch_target_o <= pc_i + {{8{branch_disp_i[7]}}, branch_disp_i};  // [RQ9]
      bit_mask_o <= 8'h01 << bit_i;  // [RQ8]
    end
  end

  write_back_a: assert property (@(posedge clock_i) disable iff (rst_i)
    swap_back |-> $past(finish)) else $error("swap second write out of step");  // [RQ17]
  abs_cycles_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(busy_o) && kind_r == OPD_ABS && swap_r && cycles_o != CYC_ABS_FAST
    |-> cycles_o == CYC_SWAP_SLOW) else $error("slow swap count wrong");  // [RQ14]
  reg_cycles_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(busy_o) && kind_r == OPD_REG |-> cycles_o == CYC_RR)
    else $error("register move count wrong");  // [RQ13]
  short_range_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state_r == ST_IDLE && start_i && kind_i == OPD_SHORT && addr_i < SHORT_LO
    |=> range_err_o && !busy_o) else $error("short range not refused");  // [RQ3]
  sfr_hole_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state_r == ST_IDLE && start_i && kind_i == OPD_SFR
    && in_range(addr_i, SFR_HOLE_LO, SFR_HOLE_HI) |=> range_err_o)
    else $error("special register hole reached");  // [RQ7]
  abs_even_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state_r == ST_IDLE && start_i && kind_i == OPD_ABS && word_i && addr_i[0]
    |=> range_err_o) else $error("odd word address taken");  // [RQ4]
  // Targets still hold reset values on the first edge after release
  call_span_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> in_range(call_target_o, CALL_LO, CALL_HI))
    else $error("call out of span");  // [RQ5]
  table_span_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> (in_range(table_target_o, TABLE_LO, TABLE_HI) && !table_target_o[0]))
    else $error("table target bad");  // [RQ6]
  flag_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
    finish && kind_r != OPD_PSW && !(kind_r == OPD_IMM && swap_r)
    |=> $stable(program_status_word_o)) else $error("flags moved");  // [RQ16]
  bit_mask_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !$past(rst_i) |-> $onehot(bit_mask_o)) else $error("bit mask not one-hot");  // [RQ8]

  reg_move_c: cover property (@(posedge clock_i) done_o && kind_r == OPD_REG);
  abs_swap_c: cover property (@(posedge clock_i) done_o && swap_r && kind_r == OPD_ABS);
  psw_load_c: cover property (@(posedge clock_i) done_o && kind_r == OPD_PSW);
  range_err_c: cover property (@(posedge clock_i) range_err_o);
endmodule : byte_move_exec
`default_nettype wire

/* verification/data_mem_model.sv */
// Behavioural data memory and special register space facing the executor
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  wdata_i,
  output logic [7:0]       rdata_o
);
  logic [7:0] store [65536];

  // Address-derived fill so a stale or wrong address reads as a match only if its two bytes XOR to the same value
  initial begin
    for (int i = 0; i < 65536; i++) begin
      store[i] = i[7:0] ^ i[15:8] ^ 8'h3C;
    end
  end

  assign rdata_o = store[addr_i];

  always @(posedge clock_i) begin
    if (we_i) begin
      store[addr_i] <= wdata_i;
    end
  end
endmodule : data_mem_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the byte move and swap execution unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  import byte_move_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start_i = 1'b0;
  logic        swap_i = 1'b0;
  logic        to_acc_i = 1'b0;
  logic        word_i = 1'b0;
  opd_kind_t   kind_i = OPD_REG;
  idx_mode_t   idx_i = IDX_NONE;
  logic [2:0]  reg_sel_i = 3'h0;
  logic [2:0]  bit_i = 3'h0;
  logic [1:0]  pair_sel_i = 2'h0;
  logic [1:0]  bank_i = 2'h0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] pc_i = 16'h0000;
  logic [7:0]  imm_i = 8'h00;
  logic [7:0]  branch_disp_i = 8'h00;
  logic [10:0] call_addr_i = 11'h000;
  logic [4:0]  table_addr_i = 5'h00;
  logic [7:0]  mem_rdata_i;
  logic        busy_o, done_o, range_err_o, mem_we_o;
  logic [15:0] mem_addr_o, word_accumulator_o, call_target_o, table_target_o, branch_target_o;
  logic [7:0]  mem_wdata_o, program_status_word_o, bit_mask_o;
  logic [3:0]  cycles_o;
  int          n_errors = 0;
  int          n_checks = 0;
  logic [7:0]  old_a;
  logic        we_seen;
  logic [7:0]  wd_seen;

  always #20 clock_i = ~clock_i;

  byte_move_exec DUT (.clock_i, .rst_i, .start_i, .swap_i, .to_acc_i, .kind_i, .reg_sel_i,
    .pair_sel_i, .idx_i, .addr_i, .imm_i, .bank_i, .word_i, .bit_i, .call_addr_i,
    .table_addr_i, .branch_disp_i, .pc_i, .mem_rdata_i, .busy_o, .done_o, .range_err_o,
    .mem_addr_o, .mem_we_o, .mem_wdata_o, .program_status_word_o, .word_accumulator_o,
    .call_target_o, .table_target_o, .branch_target_o, .bit_mask_o, .cycles_o);

  data_mem_model mem (.clock_i(clock_i), .addr_i(mem_addr_o), .we_i(mem_we_o),
    .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : pat

  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // One instruction; returns one clock after done or refusal shows,
  // since the word accumulator output lags the register write by a cycle
  task automatic run(input opd_kind_t k, input logic sw, input logic ta, input logic [2:0] rs,
                     input logic [1:0] ps, input idx_mode_t ix, input logic [15:0] ad,
                     input logic [7:0] im, input logic wd);
    int n;
    repeat (2) @(posedge clock_i);
    kind_i <= k;
    swap_i <= sw;
    to_acc_i <= ta;
    reg_sel_i <= rs;
    pair_sel_i <= ps;
    idx_i <= ix;
    addr_i <= ad;
    imm_i <= im;
    word_i <= wd;
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    n = 0;
    @(negedge clock_i);
    while (done_o !== 1'b1 && range_err_o !== 1'b1 && n < 20) begin
      @(negedge clock_i);
      n++;
    end
    we_seen = mem_we_o;
    wd_seen = mem_wdata_o;
    @(negedge clock_i);
    if (n >= 20) begin
      n_errors++;
      print_verdict();
    end
  endtask : run

  task automatic ld(input logic [2:0] rs, input logic [7:0] v, input logic ta);
    run(OPD_IMM, 1'b0, ta, rs, 2'h0, IDX_NONE, 16'h0000, v, 1'b0);
  endtask : ld

  task automatic ind(input logic [1:0] ps, input idx_mode_t ix, input logic [7:0] im,
                     input logic [15:0] ea, input logic [3:0] ec);
    run(OPD_IND, 1'b0, 1'b1, 3'h0, ps, ix, 16'h0000, im, 1'b0);
    `CHK(mem_addr_o, ea)
    `CHK(cycles_o, ec)
    `CHK(word_accumulator_o[15:8], pat(ea))
  endtask : ind

  task automatic cyc(input opd_kind_t k, input logic [15:0] ad, input logic [3:0] ec);
    run(k, 1'b0, 1'b1, 3'h0, 2'h0, IDX_NONE, ad, 8'h00, 1'b0);
    `CHK(cycles_o, ec)
    `CHK(word_accumulator_o[15:8], pat(ad))
    `CHK(range_err_o, 1'b0)
  endtask : cyc

  task automatic bad(input opd_kind_t k, input logic [15:0] ad, input logic wd);
    old_a = word_accumulator_o[15:8];
    run(k, 1'b0, 1'b1, 3'h0, 2'h0, IDX_NONE, ad, 8'h00, wd);
    `CHK({range_err_o, busy_o, done_o}, 3'b100)
    `CHK(word_accumulator_o[15:8], old_a)
  endtask : bad

  task automatic tgt(input logic [10:0] ca, input logic [4:0] ta, input logic [7:0] bd,
                     input logic [15:0] pc, input logic [2:0] bt, input logic [63:0] exp);
    @(posedge clock_i);
    call_addr_i <= ca;
    table_addr_i <= ta;
    branch_disp_i <= bd;
    pc_i <= pc;
    bit_i <= bt;
    run(OPD_REG, 1'b0, 1'b1, REG_X, 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
    `CHK({call_target_o, table_target_o, branch_target_o, bit_mask_o}, exp[55:0])
  endtask : tgt

  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    `CHK({program_status_word_o, busy_o, done_o}, {PSW_RESET, 2'b00})
    for (int i = 0; i < 8; i++) ld(i[2:0], 8'h10 + i[7:0], 1'b0);
    `CHK(word_accumulator_o, 16'h1110)
    for (int i = 7; i >= 0; i--) begin
      run(OPD_REG, 1'b0, 1'b1, i[2:0], 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
      if (i != 1) `CHK(word_accumulator_o[15:8], 8'h10 + i[7:0])
      `CHK(cycles_o, CYC_RR)
    end
    ind(2'h1, IDX_NONE, 8'h00, 16'h1312, CYC_IND_SLOW);
    ind(2'h2, IDX_NONE, 8'h00, 16'h1514, CYC_IND_SLOW);
    ind(PAIR_HL, IDX_NONE, 8'h00, 16'h1716, CYC_IND_SLOW);
    ind(PAIR_HL, IDX_DISP, 8'h20, 16'h1736, CYC_ABS_SLOW);
    ind(PAIR_HL, IDX_B, 8'h00, 16'h1729, CYC_IDX_SLOW);
    ind(PAIR_HL, IDX_C, 8'h00, 16'h1728, CYC_IDX_SLOW);
    cyc(OPD_ABS, 16'hFC00, CYC_ABS_FAST);
    cyc(OPD_ABS, 16'h1000, CYC_ABS_SLOW);
    cyc(OPD_ABS, 16'hFFFF, CYC_ABS_SLOW);
    cyc(OPD_SFR, 16'hFF10, CYC_SHORT_SLOW);
    cyc(OPD_SFR, 16'hFFE0, CYC_SHORT_SLOW);
    cyc(OPD_SHORT, 16'hFF1F, CYC_SHORT_SLOW);
    cyc(OPD_SHORT, 16'hFE20, CYC_SHORT_FAST);
    bad(OPD_SHORT, 16'hFE1F, 1'b0);
    bad(OPD_SHORT, 16'hFF20, 1'b0);
    bad(OPD_SHORT, 16'hFE21, 1'b1);
    bad(OPD_SFR, 16'hFFD0, 1'b0);
    bad(OPD_SFR, 16'hFFDF, 1'b0);
    bad(OPD_ABS, 16'h1001, 1'b1);
    old_a = word_accumulator_o[15:8];
    run(OPD_ABS, 1'b1, 1'b1, 3'h0, 2'h0, IDX_NONE, 16'h2000, 8'h00, 1'b0);
    `CHK({word_accumulator_o[15:8], we_seen, wd_seen}, {pat(16'h2000), 1'b1, old_a})
    `CHK(cycles_o, CYC_SWAP_SLOW)
    run(OPD_ABS, 1'b1, 1'b1, 3'h0, 2'h0, IDX_NONE, 16'h2000, 8'h00, 1'b0);
    `CHK(word_accumulator_o[15:8], old_a)
    ld(REG_A, 8'hFF, 1'b1);
    `CHK(program_status_word_o, PSW_RESET)
    run(OPD_PSW, 1'b0, 1'b0, 3'h0, 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
    `CHK(program_status_word_o & PSW_FLAG_MASK, PSW_FLAG_MASK)
    ld(REG_A, 8'h00, 1'b1);
    cyc(OPD_ABS, 16'h3000, CYC_ABS_SLOW);
    `CHK(program_status_word_o & PSW_FLAG_MASK, PSW_FLAG_MASK)
    ld(REG_A, 8'h00, 1'b1);
    run(OPD_PSW, 1'b0, 1'b0, 3'h0, 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
    `CHK(program_status_word_o & PSW_FLAG_MASK, 8'h00)
    run(OPD_IMM, 1'b1, 1'b0, REG_X, 2'h0, IDX_NONE, 16'h0000, 8'hC1, 1'b0);
    `CHK(program_status_word_o & PSW_FLAG_MASK, 8'h41)
    `CHK(cycles_o, CYC_PSW_IMM)
    `CHK(word_accumulator_o, 16'h0010)
    run(OPD_REG, 1'b1, 1'b1, REG_C, 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
    `CHK(word_accumulator_o[15:8], 8'h12)
    run(OPD_REG, 1'b0, 1'b1, REG_C, 2'h0, IDX_NONE, 16'h0000, 8'h00, 1'b0);
    `CHK(word_accumulator_o[15:8], 8'h00)
    @(posedge clock_i);
    bank_i <= 2'h1;
    ld(REG_X, 8'h5A, 1'b0);
    `CHK(word_accumulator_o, 16'h005A)
    @(posedge clock_i);
    bank_i <= 2'h0;
    tgt(11'h7FF, 5'h1F, 8'h80, 16'h1000, 3'h7, 64'h0FFF_007E_0F80_80);
    tgt(11'h000, 5'h00, 8'h7F, 16'hFFF0, 3'h0, 64'h0800_0040_006F_01);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
